// ---- hw/sscc_burst_ctr.sv ----
// Two-bit burst address counter.
// Assumes load and step are only raised on edges that are not stalled.
module sscc_burst_ctr (
   input wire logic  clock,
   input wire logic  rst,
   sscc_burst_if.ctr bi
);
   logic [1:0] start_q;
   logic [1:0] beat_q;
   wire  [1:0] beat_nx;

   assign beat_nx = beat_q + sscc_pkg::BEAT_STEP;
   // The low bits offered are those of the next continue beat.
   assign bi.low = (bi.order == sscc_pkg::ORDER_INTERLEAVED) ? (start_q ^ beat_nx)
                                                              : (start_q + beat_nx);

   always_ff @(posedge clock) begin
      if (rst) begin
         start_q <= sscc_pkg::BEAT_FIRST;
         beat_q  <= sscc_pkg::BEAT_FIRST;
      end else if (bi.load) begin
         start_q <= bi.start;
         beat_q  <= sscc_pkg::BEAT_FIRST;
      end else if (bi.step) begin
         beat_q <= beat_nx;
      end
   end
endmodule : sscc_burst_ctr

// ---- hw/sscc_burst_if.sv ----
// Carrier between the cycle controller and its burst address counter.
// Assumes both ends run on the same clock.
interface sscc_burst_if;
   logic       load;
   logic       step;
   logic [1:0] start;
   logic       order;
   logic [1:0] low;
   modport ctl (output load, output step, output start, output order, input low);
   modport ctr (input load, input step, input start, input order, output low);
endinterface : sscc_burst_if

// ---- hw/sscc_pkg.sv ----
// Constants and types shared by the synchronous SRAM cycle-control block.
// Assumes one 50 MHz clock shared with the memory controller that drives the pins.
package sscc_pkg;
   localparam int         CLK_PERIOD_NS     = 20;
   localparam int         SLEEP_IN_MAX_NS   = 2 * CLK_PERIOD_NS;
   localparam int         SLEEP_OUT_MAX_NS  = 2 * CLK_PERIOD_NS;
   // Longest times round down to whole cycles.
   localparam int         SLEEP_IN_MAX_CYC  = SLEEP_IN_MAX_NS / CLK_PERIOD_NS;
   localparam int         SLEEP_OUT_MAX_CYC = SLEEP_OUT_MAX_NS / CLK_PERIOD_NS;
   localparam int         ADDR_W_DEF        = 18;
   localparam int         DATA_W_DEF        = 36;
   localparam int         LANES_DEF         = 4;
   localparam logic       ORDER_LINEAR      = 1'b0;
   localparam logic       ORDER_INTERLEAVED = 1'b1;
   localparam logic [1:0] BEAT_FIRST        = 2'h0;
   localparam logic [1:0] BEAT_STEP         = 2'h1;
   localparam logic       SYNC_RST_LOW      = 1'b0;
   localparam logic       SYNC_RST_HIGH     = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_READ  = 3'h2,
      ST_WRITE = 3'h4
   } sscc_burst_t;
endpackage : sscc_pkg

// ---- hw/sscc_top.sv ----
// Cycle control, burst sequencing and sleep handling of a flow-through synchronous SRAM.
// Assumes the controller drives the synchronous pins from the same clock; sleep_request,
// burst_order and output_enable_n are asynchronous and are synchronised here.
module sscc_top #(
   parameter int ADDR_W = sscc_pkg::ADDR_W_DEF,
   parameter int DATA_W = sscc_pkg::DATA_W_DEF,
   parameter int LANES  = sscc_pkg::LANES_DEF
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              edge_gate_n,
   input  wire logic              sleep_request,
   input  wire logic              chip_select_n,
   input  wire logic              chip_select2_n,
   input  wire logic              chip_select_hi,
   input  wire logic              advance_load,
   input  wire logic              read_write_n,
   input  wire logic [LANES-1:0]  byte_write_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              burst_order,
   input  wire logic              output_enable_n,
   input  wire logic [DATA_W-1:0] dq_in,
   output wire logic [DATA_W-1:0] dq_out,
   output wire logic              dq_oe
);
   localparam int LW = DATA_W / LANES;

   logic [DATA_W-1:0]     mem [2**ADDR_W];
   logic                  sleep_s1_q;
   logic                  sleep_q;
   logic                  oe_s1_q;
   logic                  oe_n_q;
   logic                  ord_s1_q;
   logic                  ord_q;
   sscc_pkg::sscc_burst_t burst_q;
   sscc_pkg::sscc_burst_t burst_d;
   logic [ADDR_W-3:0]     base_q;
   logic                  drive_q;
   logic                  wr_pend_q;
   logic [ADDR_W-1:0]     wr_addr_q;
   logic [LANES-1:0]      wr_be_q;
   logic [DATA_W-1:0]     dq_out_q;

   sscc_burst_if bi ();

   sscc_burst_ctr u_ctr (
      .clock (clock),
      .rst   (rst),
      .bi    (bi.ctr)
   );

   wire              awake     = !sleep_q;
   wire              go        = !edge_gate_n && awake;
   wire              sel       = !chip_select_n && !chip_select2_n && chip_select_hi;
   wire              begin_cyc = go && !advance_load;
   wire              cont_cyc  = go && advance_load;
   wire              begin_rd  = begin_cyc && sel && read_write_n;
   wire              begin_wr  = begin_cyc && sel && !read_write_n;
   wire              cont_rd   = cont_cyc && (burst_q == sscc_pkg::ST_READ);
   wire              cont_wr   = cont_cyc && (burst_q == sscc_pkg::ST_WRITE);
   wire              do_rd     = begin_rd || cont_rd;
   wire              do_wr     = begin_wr || cont_wr;
   wire [LANES-1:0]  lanes_we  = ~byte_write_n;
   wire              commit    = go && wr_pend_q;
   wire [ADDR_W-1:0] cyc_addr  = advance_load ? {base_q, bi.low} : addr;
   wire              fwd_hit   = wr_pend_q && (wr_addr_q == cyc_addr);
   wire [DATA_W-1:0] mem_word  = mem[cyc_addr];
   wire [DATA_W-1:0] rd_word;

   assign bi.load  = begin_rd || begin_wr;
   assign bi.step  = cont_rd || cont_wr;
   assign bi.start = addr[1:0];
   assign bi.order = ord_q;

   // Write data trails its address by one edge, so the array can lag the newest value.
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_fwd
         assign rd_word[g*LW +: LW] = (fwd_hit && wr_be_q[g]) ? dq_in[g*LW +: LW]
                                                              : mem_word[g*LW +: LW];
      end
   endgenerate

   // Drivers follow reads only, so writes never drive whatever output_enable_n does.
   assign dq_oe  = drive_q && !oe_n_q && awake;
   assign dq_out = dq_out_q;

   // Asynchronous pins: two flops each; the first flop feeds only the second.
   always_ff @(posedge clock) begin
      if (rst) begin
         sleep_s1_q <= sscc_pkg::SYNC_RST_LOW;
         sleep_q    <= sscc_pkg::SYNC_RST_LOW;
         oe_s1_q    <= sscc_pkg::SYNC_RST_HIGH;
         oe_n_q     <= sscc_pkg::SYNC_RST_HIGH;
         ord_s1_q   <= sscc_pkg::ORDER_LINEAR;
         ord_q      <= sscc_pkg::ORDER_LINEAR;
      end else begin
         sleep_s1_q <= sleep_request;
         sleep_q    <= sleep_s1_q;
         oe_s1_q    <= output_enable_n;
         oe_n_q     <= oe_s1_q;
         ord_s1_q   <= burst_order;
         ord_q      <= ord_s1_q;
      end
   end

   always_comb begin
      burst_d = burst_q;
      if (!awake) begin
         burst_d = sscc_pkg::ST_IDLE;
      end else if (begin_cyc) begin
         if (begin_rd) begin
            burst_d = sscc_pkg::ST_READ;
         end else if (begin_wr) begin
            burst_d = sscc_pkg::ST_WRITE;
         end else begin
            burst_d = sscc_pkg::ST_IDLE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         burst_q <= sscc_pkg::ST_IDLE;
      end else begin
         case (burst_d)
            sscc_pkg::ST_IDLE:  burst_q <= sscc_pkg::ST_IDLE;
            sscc_pkg::ST_READ:  burst_q <= sscc_pkg::ST_READ;
            sscc_pkg::ST_WRITE: burst_q <= sscc_pkg::ST_WRITE;
            default:            burst_q <= sscc_pkg::ST_IDLE;
         endcase
      end
   end

   // A stalled edge changes none of these, so a read keeps driving and a write stays off.
   always_ff @(posedge clock) begin
      if (rst || !awake) begin
         drive_q   <= 1'b0;
         wr_pend_q <= 1'b0;
      end else if (go) begin
         drive_q   <= do_rd;
         wr_pend_q <= do_wr && (|lanes_we);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         base_q    <= '0;
         wr_addr_q <= '0;
         wr_be_q   <= '0;
         dq_out_q  <= '0;
      end else if (go) begin
         if (bi.load) begin
            base_q <= addr[ADDR_W-1:2];
         end
         if (do_wr) begin
            wr_addr_q <= cyc_addr;
            wr_be_q   <= lanes_we;
         end
         if (do_rd) begin
            dq_out_q <= rd_word;
         end
      end
   end

   // The array itself has no reset, as in the real part.
   always_ff @(posedge clock) begin
      for (int i = 0; i < LANES; i++) begin
         if (commit && wr_be_q[i]) begin
            mem[wr_addr_q][i*LW +: LW] <= dq_in[i*LW +: LW];
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_sleep_hiz: assert property (sleep_request ##1 sleep_request |=> !dq_oe && !commit)
      else $error("outputs driven while asleep");
   chk_sleep_entry: assert property (sleep_request ##1 sleep_request |=> sleep_q && !go)
      else $error("sleep not entered within two clocks");
   // A one-cycle low pulse on the pin may end sleep, so the check wants two high samples.
   chk_sleep_hold: assert property ((sleep_q && sleep_request) ##1 sleep_request |=> sleep_q)
      else $error("sleep left while request still high");
   chk_wake_sample: assert property (!sleep_request ##1 !sleep_request |=> !sleep_q)
      else $error("inputs not sampled within two clocks of wake");
   chk_write_off: assert property (do_wr |=> !dq_oe)
      else $error("drivers on after a write cycle");
   chk_stall_hold: assert property (edge_gate_n && awake
      |=> $stable(burst_q) && $stable(dq_out_q) && $stable(drive_q))
      else $error("state changed on a stalled edge");
   chk_stall_bus: assert property (drive_q && edge_gate_n && awake |=> drive_q)
      else $error("read bus released during a stall");
   chk_stall_nowr: assert property (edge_gate_n && awake && wr_pend_q
      |=> wr_pend_q && $stable(wr_addr_q) && $stable(wr_be_q))
      else $error("write committed on a stalled edge");
   chk_select_gate: assert property (begin_cyc && !sel |=> burst_q == sscc_pkg::ST_IDLE)
      else $error("deselected begin cycle started a burst");
   chk_cont_dir: assert property (cont_wr |=> burst_q == sscc_pkg::ST_WRITE)
      else $error("continue cycle changed burst direction");
   chk_linear_step: assert property ((bi.load && ord_q == sscc_pkg::ORDER_LINEAR)
      ##1 (bi.step && ord_q == sscc_pkg::ORDER_LINEAR)
      |-> cyc_addr[1:0] == 2'($past(addr[1:0]) + 2'h1))
      else $error("linear burst step wrong");
   chk_ileave_step: assert property ((bi.load && ord_q == sscc_pkg::ORDER_INTERLEAVED)
      ##1 (bi.step && ord_q == sscc_pkg::ORDER_INTERLEAVED)
      |-> cyc_addr[1:0] == ($past(addr[1:0]) ^ 2'h1))
      else $error("interleaved burst step wrong");
   chk_forward: assert property (do_rd && fwd_hit && (&wr_be_q) |=> dq_out_q == $past(dq_in))
      else $error("read missed forwarded write data");
   chk_sleep_flush: assert property (sleep_q |=> burst_q == sscc_pkg::ST_IDLE && !wr_pend_q)
      else $error("burst state survived sleep");
   chk_deselect_off: assert property (begin_cyc && !sel |=> !dq_oe)
      else $error("drivers on after a deselect cycle");
   chk_abort_off: assert property (begin_wr && (&byte_write_n) |=> !wr_pend_q && !dq_oe)
      else $error("write abort left a write pending or drivers on");
   chk_wake_idle: assert property ($fell(sleep_q) |-> burst_q == sscc_pkg::ST_IDLE)
      else $error("burst state present at wake");

   cov_sleep_trip: cover property (awake ##1 sleep_q [*3] ##1 awake);
   cov_fwd_read: cover property (do_rd && fwd_hit);
   cov_read_stall: cover property (drive_q && edge_gate_n ##1 cont_rd);
   cov_ileave: cover property (bi.step && ord_q == sscc_pkg::ORDER_INTERLEAVED);
   cov_abort: cover property (begin_wr && (&byte_write_n));
endmodule : sscc_top

// ---- verification/sscc_host_model.sv ----
// Host memory controller model that drives the synchronous SRAM pins.
// Assumes its tasks are called 1 ns after a rising clock edge.
module sscc_host_model (
   input  wire logic        clock,
   output logic             edge_gate_n,
   output logic             sleep_request,
   output logic             chip_select_n,
   output logic             chip_select2_n,
   output logic             chip_select_hi,
   output logic             advance_load,
   output logic             read_write_n,
   output logic [3:0]       byte_write_n,
   output logic [17:0]      addr,
   output logic             burst_order,
   output logic             output_enable_n,
   output logic [35:0]      dq_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      edge_gate_n = 1'h0;
      sleep_request = 1'h0;
      {chip_select_n, chip_select2_n, chip_select_hi} = 3'h5;
      advance_load = 1'h0;
      read_write_n = 1'h1;
      byte_write_n = 4'h0;
      addr = 18'h0;
      burst_order = 1'h0;
      output_enable_n = 1'h0;
      dq_in = 36'h0;
   end

   // One bus cycle; every field stays put until the sampling edge has passed.
   task automatic cyc(input logic gate_n, input logic adv, input logic rd,
                      input logic [2:0] sel, input logic [17:0] a, input logic [35:0] d);
      edge_gate_n = gate_n;
      advance_load = adv;
      read_write_n = rd;
      {chip_select_n, chip_select2_n, chip_select_hi} = sel;
      addr = a;
      dq_in = d;
      @(posedge clock);
      #1;
   endtask : cyc

   // Callers only raise sleep once every transfer has finished, and wake with reads only.
   task automatic nap(input logic level);
      sleep_request = level;
   endtask : nap

   // Static pins: burst order, output enable and byte write enables, held until changed.
   task automatic pins(input logic ord, input logic oe_n, input logic [3:0] bw_n);
      burst_order = ord;
      output_enable_n = oe_n;
      byte_write_n = bw_n;
   endtask : pins
endmodule : sscc_host_model

// ---- verification/sscc_top_tb_top.sv ----
// Self-checking bench for the SRAM cycle-control block.
// Assumes the host model supplies every input of the design except clock and rst, which the bench drives.
module sscc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] ON  = 3'h1;
   localparam logic [2:0] OFF = 3'h5;
   localparam logic [35:0] PAT = 36'h9_1234_5678;
   logic clock;
   logic rst;
   logic edge_gate_n, sleep_request, cs_n, cs2_n, cs_hi, adv, rw_n, order, oe_n, dq_oe;
   logic [3:0]  bw_n;
   logic [17:0] addr;
   logic [35:0] dq_in, dq_out;
   int fail_count;
   int compares;

   sscc_host_model h (.clock(clock), .edge_gate_n(edge_gate_n),
      .sleep_request(sleep_request), .chip_select_n(cs_n), .chip_select2_n(cs2_n),
      .chip_select_hi(cs_hi), .advance_load(adv), .read_write_n(rw_n),
      .byte_write_n(bw_n), .addr(addr), .burst_order(order),
      .output_enable_n(oe_n), .dq_in(dq_in));
   sscc_top dut (.clock(clock), .rst(rst), .edge_gate_n(edge_gate_n),
      .sleep_request(sleep_request), .chip_select_n(cs_n), .chip_select2_n(cs2_n),
      .chip_select_hi(cs_hi), .advance_load(adv), .read_write_n(rw_n),
      .byte_write_n(bw_n), .addr(addr), .burst_order(order),
      .output_enable_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end

   function automatic logic [35:0] word(input int k);
      return 36'h5_A5A5_A5A0 + 36'(k);
   endfunction : word

   task automatic cmp_data(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_data

   task automatic cmp_flag(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected drive at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_flag

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic t_forward();
      h.cyc(1'h0, 1'h0, 1'h0, ON, 18'h100, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, PAT);
      cmp_data(dq_out, PAT);
      cmp_flag(dq_oe, 1'h1);
   endtask : t_forward

   // Linear write burst from low bits 2, then interleaved read burst from 1.
   task automatic t_burst();
      h.cyc(1'h0, 1'h0, 1'h0, ON, 18'h202, 36'h0);
      for (int k = 1; k < 4; k++) begin
         h.cyc(1'h0, 1'h1, 1'h0, ON, 18'h0, word(k - 1));
      end
      h.cyc(1'h0, 1'h0, 1'h1, OFF, 18'h0, word(3));
      h.pins(1'h1, 1'h0, 4'h0);
      repeat (3) h.cyc(1'h0, 1'h0, 1'h1, OFF, 18'h0, 36'h0);
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h201, 36'h0);
      cmp_data(dq_out, word(3));
      for (int k = 1; k < 4; k++) begin
         h.cyc(1'h0, 1'h1, 1'h1, ON, 18'h0, 36'h0);
         cmp_data(dq_out, word(((1 ^ k) - 2) & 3));
      end
      h.pins(1'h0, 1'h0, 4'h0);
   endtask : t_burst

   task automatic t_stall();
      h.cyc(1'h1, 1'h0, 1'h1, OFF, 18'h0, 36'h0);
      cmp_flag(dq_oe, 1'h1);
      cmp_data(dq_out, word(0));
      h.cyc(1'h0, 1'h0, 1'h0, ON, 18'h300, 36'h0);
      h.cyc(1'h1, 1'h0, 1'h1, OFF, 18'h0, word(7));
      cmp_flag(dq_oe, 1'h0);
      h.cyc(1'h0, 1'h0, 1'h1, OFF, 18'h0, word(9));
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h300, 36'h0);
      cmp_data(dq_out, word(9));
   endtask : t_stall

   task automatic t_select();
      logic [2:0] bad [3] = '{3'h5, 3'h3, 3'h0};
      for (int i = 0; i < 3; i++) begin
         h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, 36'h0);
         h.cyc(1'h0, 1'h0, 1'h1, bad[i], 18'h100, 36'h0);
         cmp_flag(dq_oe, 1'h0);
      end
   endtask : t_select

   task automatic t_sleep();
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, 36'h0);
      h.nap(1'h1);
      repeat (2) h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      h.cyc(1'h0, 1'h0, 1'h0, ON, 18'h100, 36'h0);
      h.cyc(1'h0, 1'h0, 1'h1, OFF, 18'h0, word(5));
      cmp_flag(dq_oe, 1'h0);
      h.nap(1'h0);
      repeat (3) h.cyc(1'h0, 1'h1, 1'h1, ON, 18'h0, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, 36'h0);
      cmp_data(dq_out, PAT);
   endtask : t_sleep

   // Output enable high keeps the drivers off on reads; it reaches the logic two edges late.
   task automatic t_oe();
      h.pins(1'h0, 1'h1, 4'h0);
      repeat (2) h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h300, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      cmp_data(dq_out, word(9));
      h.pins(1'h0, 1'h0, 4'h0);
      repeat (2) h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h300, 36'h0);
      cmp_flag(dq_oe, 1'h1);
   endtask : t_oe

   // A reset in mid-burst clears the outputs and drops the burst.
   task automatic t_reset();
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h300, 36'h0);
      rst = 1'h1;
      repeat (2) h.cyc(1'h0, 1'h1, 1'h1, ON, 18'h0, 36'h0);
      cmp_data(dq_out, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      rst = 1'h0;
      repeat (2) h.cyc(1'h0, 1'h1, 1'h1, ON, 18'h0, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h300, 36'h0);
      cmp_data(dq_out, word(9));
      cmp_flag(dq_oe, 1'h1);
   endtask : t_reset

   // Lane 0 alone, read back at once through forwarding, then a write abort.
   task automatic t_lanes();
      h.pins(1'h0, 1'h0, 4'hE);
      h.cyc(1'h0, 1'h0, 1'h0, ON, 18'h100, 36'h0);
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, 36'h0_0000_01FF);
      cmp_data(dq_out, {PAT[35:9], 9'h1FF});
      h.pins(1'h0, 1'h0, 4'hF);
      h.cyc(1'h0, 1'h0, 1'h0, ON, 18'h100, 36'h0);
      cmp_flag(dq_oe, 1'h0);
      h.cyc(1'h0, 1'h0, 1'h1, ON, 18'h100, 36'hF_FFFF_FFFF);
      cmp_data(dq_out, {PAT[35:9], 9'h1FF});
      h.pins(1'h0, 1'h0, 4'h0);
   endtask : t_lanes

   initial begin
      fail_count = 0;
      compares = 0;
      rst = 1'h1;
      repeat (12) @(posedge clock);
      #1 rst = 1'h0;
      repeat (4) @(posedge clock);
      #1;
      t_forward();
      t_burst();
      t_stall();
      t_oe();
      t_reset();
      t_select();
      t_sleep();
      t_lanes();
      end_of_test();
   end

   initial begin
      #100us;
      fail_count++;
      end_of_test();
   end
endmodule : sscc_top_tb_top
